// *** verilog/rxfc_pkg.sv ***
// Function
// RULE1: With FCS stripping on, the four trailing FCS bytes are removed; with it off they pass.
// RULE2: A frame of eight bytes or fewer keeps its FCS even when stripping is on.
// RULE3: The strip control is changed only while the receive reset is held.
// RULE4: With error suppression off, a bad FCS raises the frame error on the last beat.
// RULE5: With error suppression on, a bad FCS does not raise the frame error but still pulses.
// RULE6: A frame longer than the maximum length is cut at that length and ends with error.
// RULE7: The maximum length lies in 64 to 16383 and its bit 14 is always zero.
// RULE8: A frame shorter than four bytes is dropped whole and nothing of it is delivered.
// RULE9: A frame shorter than the minimum length ends with the frame error raised.
// RULE10: Local fault codes are acted on when fault handling is 1 and ignored when 0.
// RULE11: The primary test-pattern control enables checking against scrambled idle.
// RULE12: The secondary test-pattern enable also enables checking, below the primary.
// RULE13: While checking, a nonzero 8-bit mismatch increment reports each bad word.
// RULE14: The pattern-kind select chooses the expected data pattern for the checker.
package rxfc_pkg;

    // ========================================================================
    // Frame geometry
    localparam logic [14:0] RXFC_RUNT_LEN   = 15'h0004;
    localparam logic [14:0] RXFC_STRIP_MAX  = 15'h0008;
    localparam logic [2:0]  RXFC_FCS_BYTES  = 3'h4;
    localparam logic [2:0]  RXFC_HOLD_BYTES = 3'h5;
    localparam int          RXFC_FIFO_DEPTH = 32;

    // ========================================================================
    // Expected words for the pattern checker, one byte per lane
    localparam logic [63:0] RXFC_PAT_IDLE  = 64'h0707070707070707;
    localparam logic [63:0] RXFC_PAT_LF    = 64'h0100009C0100009C;
    localparam logic [63:0] RXFC_PAT_ZERO  = 64'h0000000000000000;
    localparam logic [7:0]  RXFC_ERR_RESET = 8'h00;

    // ========================================================================
    // Types
    typedef enum logic [1:0] {
        RXFC_PAT_OFF,
        RXFC_PAT_SCR_IDLE,
        RXFC_PAT_DATA_LF,
        RXFC_PAT_DATA_ZERO
    } rxfc_pat_mode_t;

    typedef struct packed {
        logic [7:0] data;
        logic       last;
        logic       err;
    } rxfc_beat_t;

endpackage : rxfc_pkg

// *** verilog/rxfc_fifo.sv ***
`timescale 1ns/10ps
module rxfc_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [CW-1:0]    count_r;
    logic             wr_en;
    logic             rd_en;

    assign in_ready = (count_r != CW'(DEPTH));
    assign wr_en    = in_valid && in_ready;
    // Output register is refilled as soon as it empties or is taken
    assign rd_en    = (count_r != '0) && (!out_valid || out_ready);

    always_ff @(posedge ref_clk) begin
        if (wr_en) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            if (wr_en) wr_ptr_r <= wr_ptr_r + 1'b1;
            if (rd_en) rd_ptr_r <= rd_ptr_r + 1'b1;
            count_r <= count_r + CW'(wr_en) - CW'(rd_en);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            out_valid <= 1'b0;
            out_data  <= '0;
        end else if (rd_en) begin
            out_valid <= 1'b1;
            out_data  <= mem_r[rd_ptr_r];
        end else if (out_ready) begin
            out_valid <= 1'b0;
        end
    end

    fifo_full_c : cover property (@(posedge ref_clk) disable iff (rst) !in_ready);

endmodule : rxfc_fifo

// *** verilog/rxfc_pat_chk.sv ***
`timescale 1ns/10ps
module rxfc_pat_chk (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // Controls
    input  wire logic        pat_primary,
    input  wire logic        pat_alt,
    input  wire logic        pat_sel,
    // Decoded block stream
    input  wire logic        blk_valid,
    input  wire logic [63:0] blk_data,
    // Mismatch increment
    output logic      [7:0]  err_inc,
    output logic             err_valid
);
    rxfc_pkg::rxfc_pat_mode_t mode;
    logic [63:0]              expect_w;
    logic [7:0]               miss;

    // Primary control wins: it forces scrambled idle whatever the select says
    always_comb begin
        if (pat_primary) begin
            mode = rxfc_pkg::RXFC_PAT_SCR_IDLE;                 // RULE11
        end else if (pat_alt) begin
            mode = pat_sel ? rxfc_pkg::RXFC_PAT_DATA_ZERO       // RULE12
                           : rxfc_pkg::RXFC_PAT_DATA_LF;        // RULE14
        end else begin
            mode = rxfc_pkg::RXFC_PAT_OFF;
        end
    end

    always_comb begin
        case (mode)
            rxfc_pkg::RXFC_PAT_SCR_IDLE:  expect_w = rxfc_pkg::RXFC_PAT_IDLE;
            rxfc_pkg::RXFC_PAT_DATA_LF:   expect_w = rxfc_pkg::RXFC_PAT_LF;
            rxfc_pkg::RXFC_PAT_DATA_ZERO: expect_w = rxfc_pkg::RXFC_PAT_ZERO;
            default:                      expect_w = rxfc_pkg::RXFC_PAT_IDLE;
        endcase
    end

    // One count per mismatched lane, so the increment is never zero on a miss
    always_comb begin
        miss = 8'h00;
        for (int i = 0; i < 8; i++) begin
            miss = miss + 8'(blk_data[i*8 +: 8] != expect_w[i*8 +: 8]);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            err_inc   <= rxfc_pkg::RXFC_ERR_RESET;
            err_valid <= 1'b0;
        end else begin
            err_valid <= blk_valid && (mode != rxfc_pkg::RXFC_PAT_OFF);
            err_inc   <= (blk_valid && (mode != rxfc_pkg::RXFC_PAT_OFF)) ? miss  // RULE13
                                                                        : 8'h00;
        end
    end

    pat_miss_a : assert property (@(posedge ref_clk) disable iff (rst) // RULE13
        (blk_valid && (pat_primary || pat_alt) && (miss != 8'h00)) |=> (err_inc == $past(miss)))
        else $error("pattern mismatch not reported");
    pat_prio_a : assert property (@(posedge ref_clk) disable iff (rst) // RULE12
        (pat_primary && pat_alt) |-> (expect_w == rxfc_pkg::RXFC_PAT_IDLE))
        else $error("secondary pattern enable overrode primary");
    pat_quiet_a : assert property (@(posedge ref_clk) disable iff (rst) // RULE11
        !(pat_primary || pat_alt) |=> (err_inc == 8'h00))
        else $error("pattern error reported while checking is off");

endmodule : rxfc_pat_chk

// *** verilog/rxfc_top.sv ***
`timescale 1ns/10ps
module rxfc_top (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // Frame controls
    input  wire logic        ctl_strip_fcs,
    input  wire logic        ctl_ignore_fcs_err,
    input  wire logic [14:0] ctl_max_len,
    input  wire logic [7:0]  ctl_min_len,
    input  wire logic        ctl_process_lf,
    // Test-pattern controls
    input  wire logic        ctl_test_pattern,
    input  wire logic        ctl_test_pattern_alt,
    input  wire logic        ctl_data_pattern_sel,
    // Byte stream from the PCS
    input  wire logic        pcs_valid,
    output logic             pcs_ready,
    input  wire logic [7:0]  pcs_data,
    input  wire logic        pcs_eof,
    input  wire logic        pcs_fcs_bad,
    input  wire logic        pcs_lf,
    // Decoded block stream for the pattern checker
    input  wire logic        blk_valid,
    input  wire logic [63:0] blk_data,
    // User packet interface
    output logic             usr_valid,
    input  wire logic        usr_ready,
    output logic      [7:0]  usr_data,
    output logic             usr_eof,
    output logic             usr_err,
    // Status
    output logic             stat_bad_fcs,
    output logic             stat_local_fault,
    output logic      [7:0]  stat_test_err,
    output logic             stat_test_err_valid
);

    // ========================================================================
    // Framing state
    typedef enum logic [1:0] {
        ST_RECV,
        ST_FLUSH,
        ST_SKIP
    } rxfc_state_t;

    rxfc_state_t         state_r;
    logic [4:0][7:0]     hold_r;
    logic [2:0]          hold_cnt_r;
    logic [14:0]         len_r;
    logic [2:0]          fl_idx_r;
    logic [2:0]          fl_left_r;
    logic                fl_err_r;
    logic                fl_skip_r;
    logic                stat_bad_fcs_r;
    logic                stat_local_fault_r;

    logic                accept;
    logic                fin_ready;
    logic                fin_valid;
    rxfc_pkg::rxfc_beat_t fin_beat;
    rxfc_pkg::rxfc_beat_t fout_beat;
    logic [14:0]         len_nxt;
    logic [2:0]          cnt_after;
    logic                term;
    logic                runt;
    logic                trunc;
    logic                strip_now;
    logic                under;
    logic                crc_err;
    logic [2:0]          flush_cnt;

    // ========================================================================
    // Frame decisions
    // Five bytes are held back: four may be FCS and the fifth must carry the
    // end marker once the FCS is cut away, which costs five cycles of latency.
    assign pcs_ready = (state_r == ST_SKIP) || ((state_r == ST_RECV) && fin_ready);
    assign accept    = pcs_valid && pcs_ready;
    assign len_nxt   = len_r + 15'h0001;
    assign cnt_after = (hold_cnt_r == rxfc_pkg::RXFC_HOLD_BYTES) ? rxfc_pkg::RXFC_HOLD_BYTES
                                                                  : hold_cnt_r + 3'h1;
    // Reaching the maximum without an end cuts the frame at that length
    assign term      = pcs_eof || (len_nxt == ctl_max_len);                    // RULE6
    assign trunc     = !pcs_eof;
    assign runt      = pcs_eof && (len_nxt < rxfc_pkg::RXFC_RUNT_LEN);         // RULE8
    // The strip control is read live; it is only stable if changed under reset
    assign strip_now = ctl_strip_fcs && pcs_eof                                // RULE3
                       && (len_nxt > rxfc_pkg::RXFC_STRIP_MAX);                // RULE2
    assign under     = (len_nxt < {7'h00, ctl_min_len});                       // RULE9
    assign crc_err   = pcs_eof && pcs_fcs_bad && !ctl_ignore_fcs_err;          // RULE5
    assign flush_cnt = strip_now ? (cnt_after - rxfc_pkg::RXFC_FCS_BYTES)      // RULE1
                                 : cnt_after;

    // ========================================================================
    // Framing sequence
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_r <= ST_RECV;
        end else begin
            case (state_r)
                ST_RECV: begin
                    if (accept && term && !runt) begin
                        state_r <= ST_FLUSH;
                    end
                end
                ST_FLUSH: begin
                    if (fin_ready && (fl_left_r == 3'h1)) begin
                        state_r <= fl_skip_r ? ST_SKIP : ST_RECV;
                    end
                end
                ST_SKIP: begin
                    if (accept && pcs_eof) begin
                        state_r <= ST_RECV;
                    end
                end
                default: state_r <= ST_RECV;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            hold_r     <= '0;
            hold_cnt_r <= 3'h0;
            len_r      <= 15'h0000;
        end else if ((state_r == ST_RECV) && accept) begin
            if (hold_cnt_r == rxfc_pkg::RXFC_HOLD_BYTES) begin
                hold_r <= {pcs_data, hold_r[4:1]};
            end else begin
                hold_r[hold_cnt_r] <= pcs_data;
            end
            hold_cnt_r <= term ? 3'h0 : cnt_after;
            len_r      <= term ? 15'h0000 : len_nxt;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fl_idx_r  <= 3'h0;
            fl_left_r <= 3'h0;
            fl_err_r  <= 1'b0;
            fl_skip_r <= 1'b0;
        end else if ((state_r == ST_RECV) && accept && term) begin
            fl_idx_r  <= 3'h0;
            fl_left_r <= runt ? 3'h0 : flush_cnt;
            fl_err_r  <= trunc || under || crc_err;                            // RULE4
            fl_skip_r <= trunc;
        end else if ((state_r == ST_FLUSH) && fin_ready) begin
            fl_idx_r  <= fl_idx_r + 3'h1;
            fl_left_r <= fl_left_r - 3'h1;
        end
    end

    // ========================================================================
    // Beats into the buffer
    always_comb begin
        fin_valid = 1'b0;
        fin_beat  = '0;
        if (state_r == ST_FLUSH) begin
            fin_valid     = 1'b1;
            fin_beat.data = hold_r[fl_idx_r];
            fin_beat.last = (fl_left_r == 3'h1);
            fin_beat.err  = (fl_left_r == 3'h1) && fl_err_r;
        end else if ((state_r == ST_RECV) && accept
                     && (hold_cnt_r == rxfc_pkg::RXFC_HOLD_BYTES)) begin
            fin_valid     = 1'b1;
            fin_beat.data = hold_r[0];
        end
    end

    rxfc_fifo #(
        .WIDTH ($bits(rxfc_pkg::rxfc_beat_t)),
        .DEPTH (rxfc_pkg::RXFC_FIFO_DEPTH)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .in_valid  (fin_valid),
        .in_ready  (fin_ready),
        .in_data   (fin_beat),
        .out_valid (usr_valid),
        .out_ready (usr_ready),
        .out_data  (fout_beat)
    );

    assign usr_data = fout_beat.data;
    assign usr_eof  = fout_beat.last;
    assign usr_err  = fout_beat.err;

    // ========================================================================
    // Status
    // The bad-FCS pulse fires even when the user-side error is suppressed
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            stat_bad_fcs_r <= 1'b0;
        end else begin
            stat_bad_fcs_r <= (state_r == ST_RECV) && accept && pcs_eof && pcs_fcs_bad;  // RULE5
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            stat_local_fault_r <= 1'b0;
        end else begin
            stat_local_fault_r <= ctl_process_lf && pcs_lf;                    // RULE10
        end
    end

    assign stat_bad_fcs     = stat_bad_fcs_r;
    assign stat_local_fault = stat_local_fault_r;

    rxfc_pat_chk u_pat_chk (
        .ref_clk     (ref_clk),
        .rst         (rst),
        .pat_primary (ctl_test_pattern),
        .pat_alt     (ctl_test_pattern_alt),
        .pat_sel     (ctl_data_pattern_sel),
        .blk_valid   (blk_valid),
        .blk_data    (blk_data),
        .err_inc     (stat_test_err),
        .err_valid   (stat_test_err_valid)
    );

    // ========================================================================
    // Checks
    strip_fcs_a : assert property (@(posedge ref_clk) disable iff (rst) // RULE1
        ((state_r == ST_RECV) && accept && pcs_eof && ctl_strip_fcs
         && (len_nxt > rxfc_pkg::RXFC_STRIP_MAX)) |=> (state_r == ST_FLUSH) && (fl_left_r == 3'h1))
        else $error("FCS not stripped from long frame");
    keep_fcs_a : assert property (@(posedge ref_clk) disable iff (rst) // RULE2
        ((state_r == ST_RECV) && accept && pcs_eof && !runt
         && (len_nxt <= rxfc_pkg::RXFC_STRIP_MAX)) |=> (fl_left_r == $past(cnt_after)))
        else $error("FCS removed from short frame");
    crc_flag_a : assert property (@(posedge ref_clk) disable iff (rst) // RULE4
        ((state_r == ST_RECV) && accept && pcs_eof && pcs_fcs_bad && !ctl_ignore_fcs_err
         && !runt) |=> (state_r == ST_FLUSH) && fl_err_r)
        else $error("bad FCS frame ended without error");
    crc_quiet_a : assert property (@(posedge ref_clk) disable iff (rst) // RULE5
        ((state_r == ST_RECV) && accept && pcs_eof && pcs_fcs_bad && ctl_ignore_fcs_err
         && !runt && !under) |=> (!fl_err_r && stat_bad_fcs))
        else $error("suppressed FCS error leaked or pulse missing");
    trunc_len_a : assert property (@(posedge ref_clk) disable iff (rst) // RULE6
        ((state_r == ST_RECV) && accept && !pcs_eof && (len_nxt == ctl_max_len))
        |=> (state_r == ST_FLUSH) && fl_err_r && fl_skip_r)
        else $error("oversize frame not truncated with error");
    runt_drop_a : assert property (@(posedge ref_clk) disable iff (rst) // RULE8
        ((state_r == ST_RECV) && accept && runt) |=> (state_r == ST_RECV) && !fin_valid)
        else $error("runt frame reached the user side");
    under_flag_a : assert property (@(posedge ref_clk) disable iff (rst) // RULE9
        ((state_r == ST_RECV) && accept && pcs_eof && !runt && under) |=> fl_err_r)
        else $error("undersize frame ended without error");
    lf_gate_a : assert property (@(posedge ref_clk) disable iff (rst) // RULE10
        (!ctl_process_lf) |=> !stat_local_fault)
        else $error("local fault reported while handling is off");
    skip_tail_a : assert property (@(posedge ref_clk) disable iff (rst) // RULE6
        (state_r == ST_SKIP) |-> !fin_valid)
        else $error("tail of truncated frame delivered");

    strip_c : cover property (@(posedge ref_clk) disable iff (rst)
        (state_r == ST_RECV) && accept && strip_now);
    trunc_c : cover property (@(posedge ref_clk) disable iff (rst)
        (state_r == ST_RECV) && accept && term && trunc);
    runt_c : cover property (@(posedge ref_clk) disable iff (rst)
        (state_r == ST_RECV) && accept && runt);
    err_out_c : cover property (@(posedge ref_clk) disable iff (rst)
        usr_valid && usr_ready && usr_eof && usr_err);

endmodule : rxfc_top

// *** verif/rxfc_usr_sink.sv ***
`timescale 1ns/10ps
// ============================================================================
// User-side sink: random back-pressure, or a long stall on request
module rxfc_usr_sink (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst,
    // Beat stream
    input  wire logic       usr_valid,
    output logic            usr_ready,
    input  wire logic [7:0] usr_data,
    input  wire logic       usr_eof,
    input  wire logic       usr_err,
    // Stall request
    input  wire logic       hold
);
    rxfc_pkg::rxfc_beat_t got[$];

    initial usr_ready = 1'b0;

    always @(posedge ref_clk) begin
        if (!rst && usr_valid && usr_ready) begin
            got.push_back('{data: usr_data, last: usr_eof, err: usr_err});
        end
        usr_ready <= #1 !hold && ($urandom_range(3, 0) != 0);
    end
endmodule : rxfc_usr_sink

// *** verif/rxfc_top_test.sv ***
`timescale 1ns/10ps
module rxfc_top_test;
    logic        ref_clk, rst, ctl_strip_fcs, ctl_ignore_fcs_err, ctl_process_lf;
    logic [14:0] ctl_max_len;
    logic [7:0]  ctl_min_len, pcs_data, usr_data, stat_test_err, te_exp;
    logic        ctl_test_pattern, ctl_test_pattern_alt, ctl_data_pattern_sel;
    logic        pcs_valid, pcs_ready, pcs_eof, pcs_fcs_bad, pcs_lf, blk_valid, hold;
    logic [63:0] blk_data;
    logic        usr_valid, usr_ready, usr_eof, usr_err, lf_exp, tv_exp;
    logic        stat_bad_fcs, stat_local_fault, stat_test_err_valid;
    logic [7:0]  sent[$];
    logic [63:0] pats[3];
    int          bad_count, tests_run, pulses;
    int          corner[11] = '{1, 3, 4, 5, 8, 9, 12, 63, 64, 65, 100};

    rxfc_top dut (.ref_clk, .rst, .ctl_strip_fcs, .ctl_ignore_fcs_err, .ctl_max_len,
        .ctl_min_len, .ctl_process_lf, .ctl_test_pattern, .ctl_test_pattern_alt,
        .ctl_data_pattern_sel, .pcs_valid, .pcs_ready, .pcs_data, .pcs_eof, .pcs_fcs_bad,
        .pcs_lf, .blk_valid, .blk_data, .usr_valid, .usr_ready, .usr_data, .usr_eof,
        .usr_err, .stat_bad_fcs, .stat_local_fault, .stat_test_err, .stat_test_err_valid);
    rxfc_usr_sink sink (.ref_clk, .rst, .usr_valid, .usr_ready, .usr_data, .usr_eof,
        .usr_err, .hold);

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    // ========================================================================
    // Compare and finish
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask : chk

    task automatic complete_run;
        $display("Checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run

    function automatic logic [7:0] bad_lanes(input logic [63:0] d, input logic [63:0] e);
        logic [7:0] n;
        n = 8'h00;
        for (int i = 0; i < 8; i++) if (d[8*i+:8] !== e[8*i+:8]) n++;
        return n;
    endfunction : bad_lanes

    // ========================================================================
    // Status side: random controls and words, checked half a cycle after the update
    always @(posedge ref_clk) begin
        lf_exp <= !rst && ctl_process_lf && pcs_lf;
        tv_exp <= !rst && blk_valid && (ctl_test_pattern || ctl_test_pattern_alt);
        te_exp <= bad_lanes(blk_data, ctl_test_pattern ? rxfc_pkg::RXFC_PAT_IDLE :
            ctl_data_pattern_sel ? rxfc_pkg::RXFC_PAT_ZERO : rxfc_pkg::RXFC_PAT_LF);
        if (stat_bad_fcs) pulses++;
        ctl_process_lf       <= #1 1'($urandom_range(1, 0));
        pcs_lf               <= #1 1'($urandom_range(1, 0));
        blk_valid            <= #1 1'($urandom_range(1, 0));
        ctl_test_pattern     <= #1 ($urandom_range(3, 0) == 0);
        ctl_test_pattern_alt <= #1 1'($urandom_range(1, 0));
        ctl_data_pattern_sel <= #1 1'($urandom_range(1, 0));
        // Half the words carry one flipped lane so both outcomes occur
        blk_data <= #1 pats[$urandom_range(2, 0)]
            ^ (64'($urandom_range(1, 0)) << (8 * $urandom_range(7, 0)));
    end

    always @(negedge ref_clk) if (!rst) begin
        chk(16'(stat_local_fault), 16'(lf_exp), "local fault");
        chk(16'(stat_test_err_valid), 16'(tv_exp), "pattern valid");
        chk(16'(stat_test_err), tv_exp ? 16'(te_exp) : 16'h0000, "pattern errors");
    end

    // ========================================================================
    // Frame traffic
    task automatic reset_with(input logic s);
        rst = 1'b1;
        repeat (2) @(posedge ref_clk);
        #1 ctl_strip_fcs = s;
        repeat (4) @(posedge ref_clk);
        #1 rst = 1'b0;
    endtask : reset_with

    task automatic send_frame(input int n, input logic bad);
        int w;
        sent.delete();
        for (int i = 0; i < n; i++) begin
            pcs_valid   = 1'b1;
            pcs_data    = 8'($urandom);
            pcs_eof     = (i == n - 1);
            pcs_fcs_bad = bad && (i == n - 1);
            sent.push_back(pcs_data);
            w = 0;
            while (pcs_ready !== 1'b1 && w < 300) begin
                @(posedge ref_clk);
                #1 w++;
            end
            @(posedge ref_clk);
            #1;
        end
        pcs_valid   = 1'b0;
        pcs_eof     = 1'b0;
        pcs_fcs_bad = 1'b0;
    endtask : send_frame

    task automatic run_frame(input int n, input logic bad, input int mx);
        int   ne, w, p0;
        logic e;
        ctl_max_len        = 15'(mx);
        ctl_min_len        = 8'($urandom_range(80, 0));
        ctl_ignore_fcs_err = 1'($urandom_range(1, 0));
        sink.got.delete();
        p0 = pulses;
        send_frame(n, bad);
        ne = (n < 4) ? 0 : (n > mx) ? mx : (ctl_strip_fcs && n > 8) ? n - 4 : n;
        e = (n > mx) || (n < ctl_min_len) || (bad && !ctl_ignore_fcs_err);
        w = 0;
        while (sink.got.size() < ne && w < 500) begin
            @(posedge ref_clk);
            w++;
        end
        // Extra cycles let any surplus beat show up before the count is taken
        repeat (20) @(posedge ref_clk);
        // Next drive must land off the edge, not in its time step
        #1;
        chk(16'(sink.got.size()), 16'(ne), "beat count");
        foreach (sink.got[i]) begin
            chk(16'(sink.got[i].data), 16'(sent[i]), "data");
            chk(16'(sink.got[i].last), 16'(i == ne - 1), "eof");
            chk(16'(sink.got[i].err), 16'(e && i == ne - 1), "err");
        end
        chk(16'(pulses - p0), 16'(bad && n <= mx), "bad fcs pulse");
    endtask : run_frame

    initial begin
        pats = '{rxfc_pkg::RXFC_PAT_IDLE, rxfc_pkg::RXFC_PAT_LF, rxfc_pkg::RXFC_PAT_ZERO};
        {ctl_process_lf, pcs_lf, blk_valid, ctl_test_pattern, ctl_test_pattern_alt} = '0;
        {ctl_data_pattern_sel, pcs_valid, pcs_eof, pcs_fcs_bad, hold} = '0;
        {ctl_strip_fcs, ctl_ignore_fcs_err, pcs_data, blk_data} = '0;
        ctl_max_len = 15'h0040;
        ctl_min_len = 8'h40;
        void'($urandom(86776));
        reset_with(1'b0);
        for (int pass = 0; pass < 2; pass++) begin
            if (pass == 1) reset_with(1'b1);
            foreach (corner[i]) run_frame(corner[i], 1'(i % 2), 64);
            repeat (15) run_frame($urandom_range(90, 1), 1'($urandom_range(1, 0)),
                64 + $urandom_range(30, 0));
            // Long stall fills the buffer so the input side is refused
            hold = 1'b1;
            fork
                begin
                    repeat (150) @(posedge ref_clk);
                    hold <= #1 1'b0;
                end
            join_none
            run_frame(94, 1'b0, 94);
        end
        complete_run();
    end

    initial begin
        repeat (60000) @(posedge ref_clk);
        bad_count++;
        $display("BAD %0t watchdog expired", $time);
        complete_run();
    end
endmodule : rxfc_top_test
